// file: analog_out_freq_in_scaling.sv
`timescale 1ns/1ps
`include "scaling_cfg.svh"

// How it works
// [R1] each output picks its source by function code; unlisted codes give zero
// [R2] speed reference and actual speed scale against maximum speed setting
// [R3] output and active current scale against twice rated drive current
// [R4] power full scale is 1.5 x root three x rated current x K
// [R5] torque full scale is 200.0 percent
// [R6] logic value and three user values use 32767 as full scale
// [R7] motor overload and external controller output use 100 percent full scale
// [R8] a gain 0.000 to 9.999 multiplies source over full scale
// [R9] six span codes per output, both default to 0-10 V
// [R10] direct spans are ratio times width, 4-20 mA adds 4 mA
// [R11] reversed spans are span top minus ratio times width
// [R12] pulse frequency on the fast input becomes a 10-bit proportional value
// [R13] min and max band settings map frequency to percent; hertz published apart
// [R14] frequency input sits on the second digital input, 10 to 20000 Hz
// [R15] frequency value filtered with the third input's filter constant
// [R16] percent readback -100.0 to 100.0 after offset and gain
// [R17] hertz readback in whole hertz, 0 to 20000
// [R18] frequency input and readbacks work only when enabled
// [R19] source drives an NPN-style signal at or below 20 kHz
// [R20] percent = ((f - min) / (max - min) x 100 + offset) x gain
// [R21] enabled overrides digital function and status bit; disabled zeroes readbacks
// [R22] each output publishes percent of full scale after gain, 0.0 to 100.0
// [R23] output level clamps to span endpoints outside ratio zero to one
module analog_out_freq_in_scaling
    import scaling_pkg::*;
#(
    parameter int unsigned GATE_CYCLES = `GATE_TIME_MS * `CLK_FREQ_KHZ,
    parameter int unsigned TICK_CYCLES = `FILT_TICK_MS * `CLK_FREQ_KHZ
) (
    input  wire logic               clock_in,                    // 20 MHz clock
    input  wire logic               rst_n_in,                    // sync reset, active low
    input  wire logic [7:0]         output1_source_select_in,    // first output function
    input  wire logic [7:0]         output2_source_select_in,    // second output function
    input  wire logic [15:0]        output1_gain_in,             // gain x1000
    input  wire logic [15:0]        output2_gain_in,             // gain x1000
    input  wire logic [7:0]         output1_span_select_in,      // first output span
    input  wire logic [7:0]         output2_span_select_in,      // second output span
    input  wire logic signed [15:0] ramp_input_speed_in,         // rpm
    input  wire logic signed [15:0] actual_output_speed_in,      // rpm
    input  wire logic [15:0]        maximum_speed_setting_in,    // rpm
    input  wire logic [15:0]        output_current_in,           // 0.1 A rms
    input  wire logic signed [15:0] active_current_in,           // 0.1 A
    input  wire logic [31:0]        output_power_in,             // watts
    input  wire logic signed [15:0] motor_torque_in,             // 0.1 % of rated
    input  wire logic signed [15:0] logic_value_in,              // raw
    input  wire logic [15:0]        motor_overload_level_in,     // 0.1 %
    input  wire logic signed [15:0] user_value_a_in,             // raw
    input  wire logic signed [15:0] user_value_b_in,             // raw
    input  wire logic signed [15:0] user_value_c_in,             // raw
    input  wire logic signed [15:0] external_controller_output_in, // 0.1 %
    input  wire logic [15:0]        rated_drive_current_in,      // 0.1 A
    input  wire logic [1:0]         supply_voltage_setting_in,   // K select
    input  wire logic               second_digital_input_in,     // pulse pin
    input  wire logic               pulse_input_enable_in,       // frequency input on
    input  wire logic [15:0]        pulse_input_gain_in,         // gain x1000
    input  wire logic [15:0]        pulse_band_minimum_in,       // Hz
    input  wire logic [15:0]        pulse_band_maximum_in,       // Hz
    input  wire logic signed [15:0] pulse_input_offset_in,       // 0.1 %
    input  wire logic [10:0]        shared_filter_constant_in,   // 10 ms units
    output logic [15:0]             pulse_input_percent_out,     // 0.1 %, signed
    output logic [15:0]             pulse_input_hertz_out,       // Hz
    output logic signed [15:0]      pulse_input_filtered_out,    // filtered 0.1 %
    output logic                    digital_input_status_out,    // status bit of pin
    output logic                    second_input_function_out,   // pin function in use
    output logic [9:0]              output1_percent_readback_out, // 0.1 %
    output logic [9:0]              output2_percent_readback_out, // 0.1 %
    output logic [15:0]             first_level_output_out,      // mV or uA
    output logic [15:0]             second_level_output_out      // mV or uA
);

    scaling_state_t st_r;
    scaling_state_t st_nxt;

    function automatic logic signed [47:0] src_of(input logic [7:0] code);
        case (code)                                                            // R1
            `FN_SPEED_REF:      src_of = 48'(ramp_input_speed_in);
            `FN_ACTUAL_SPEED:   src_of = 48'(actual_output_speed_in);
            `FN_OUT_CURRENT:    src_of = 48'($signed({1'b0, output_current_in}));
            `FN_ACTIVE_CURRENT: src_of = 48'(active_current_in);
            `FN_OUT_POWER:      src_of = 48'($signed({1'b0, output_power_in}));
            `FN_TORQUE:         src_of = 48'(motor_torque_in);
            `FN_LOGIC_VALUE:    src_of = 48'(logic_value_in);
            `FN_OVERLOAD:       src_of = 48'($signed({1'b0, motor_overload_level_in}));
            `FN_USER_A:         src_of = 48'(user_value_a_in);
            `FN_USER_B:         src_of = 48'(user_value_b_in);
            `FN_USER_C:         src_of = 48'(user_value_c_in);
            `FN_EXT_CONTROLLER: src_of = 48'(external_controller_output_in);
            default:            src_of = '0;
        endcase
    endfunction

    function automatic logic signed [47:0] fs_of(input logic [7:0] code);
        logic signed [47:0] k;
        logic signed [47:0] rated;
        rated = $signed({32'h0, rated_drive_current_in});
        case (supply_voltage_setting_in)
            2'h1:    k = `K_SUPPLY_1;
            2'h2:    k = `K_SUPPLY_2;
            default: k = `K_SUPPLY_0;
        endcase
        case (code)
            `FN_SPEED_REF,
            `FN_ACTUAL_SPEED:   fs_of = $signed({32'h0, maximum_speed_setting_in}); // R2
            `FN_OUT_CURRENT,
            `FN_ACTIVE_CURRENT: fs_of = rated <<< 1;                           // R3
            `FN_OUT_POWER:      fs_of = rated * k * `POWER_ROOT_X1000 / 48'sd10000; // R4
            `FN_TORQUE:         fs_of = 48'(`FS_TORQUE_0P1PCT);                // R5
            `FN_LOGIC_VALUE,
            `FN_USER_A,
            `FN_USER_B,
            `FN_USER_C:         fs_of = 48'(`FS_RAW_VALUE);                    // R6
            `FN_OVERLOAD,
            `FN_EXT_CONTROLLER: fs_of = 48'(`FS_PERCENT_0P1PCT);               // R7
            default:            fs_of = '0;
        endcase
    endfunction

    // ratio of source over full scale times gain, in 0.1 % clamped to 0..100.0
    function automatic logic [9:0] ao_ratio(input logic [7:0]  code,
                                            input logic [15:0] gain);
        logic signed [47:0] src;
        logic signed [47:0] fs;
        logic signed [47:0] r;
        src = src_of(code);
        fs  = fs_of(code);
        r   = '0;
        if (fs > 0) begin
            r = src * 48'sd1000 / fs;
            r = r * $signed({32'h0, gain}) / 48'sd1000;                        // R8
        end
        if (r < 0) begin
            ao_ratio = '0;                                                     // R23
        end else if (r > 48'($signed({1'b0, `PCT_FULL}))) begin
            ao_ratio = 10'(`PCT_FULL);                                         // R23
        end else begin
            ao_ratio = r[9:0];                                                 // R22
        end
    endfunction

    // electrical level in mV or uA for a span
    function automatic logic [15:0] level_of(input logic [7:0] span,
                                             input logic [9:0] pct);
        logic [31:0] p;
        p = {22'h0, pct};
        case (span)                                                            // R9
            `SPAN_0_20MA: level_of = 16'(p * `LVL_20MA / `PCT_FULL);           // R10
            `SPAN_4_20MA: level_of = 16'(p * `LVL_16MA / `PCT_FULL) + `LVL_4MA; // R10
            `SPAN_10_0V:  level_of = `LVL_10V - 16'(p * `LVL_10V / `PCT_FULL); // R11
            `SPAN_20_0MA: level_of = `LVL_20MA - 16'(p * `LVL_20MA / `PCT_FULL); // R11
            `SPAN_20_4MA: level_of = `LVL_20MA - 16'(p * `LVL_16MA / `PCT_FULL); // R11
            default:      level_of = 16'(p * `LVL_10V / `PCT_FULL);            // R10
        endcase
    endfunction

    // frequency to 10-bit ratio, then percent with offset and gain
    function automatic logic signed [15:0] hz_to_pct(input logic [15:0] hz);
        logic signed [31:0] span;
        logic signed [31:0] q;
        logic signed [31:0] p;
        span = $signed({16'h0, pulse_band_maximum_in}) - $signed({16'h0, pulse_band_minimum_in});
        q    = '0;
        if (span > 0) begin
            q = ($signed({16'h0, hz}) - $signed({16'h0, pulse_band_minimum_in}))
                * `RATIO_10BIT_MAX / span;                                     // R13
        end
        if (q < 0) begin
            q = '0;
        end else if (q > `RATIO_10BIT_MAX) begin
            q = `RATIO_10BIT_MAX;                                              // R12
        end
        p = q * 32'sd1000 / `RATIO_10BIT_MAX + 32'(pulse_input_offset_in);     // R20
        p = p * $signed({16'h0, pulse_input_gain_in}) / 32'sd1000;             // R20
        if (p > 32'sd1000) begin
            p = 32'sd1000;                                                     // R16
        end else if (p < -32'sd1000) begin
            p = -32'sd1000;                                                    // R16
        end
        hz_to_pct = p[15:0];
    endfunction

    always_comb begin
        logic               rise;
        logic signed [31:0] target;
        logic signed [31:0] delta;
        rise   = st_r.pin_sync & ~st_r.pin_prev;
        target = '0;
        delta  = '0;
        st_nxt = st_r;

        st_nxt.pin_meta = second_digital_input_in;                             // R14
        st_nxt.pin_sync = st_r.pin_meta;
        st_nxt.pin_prev = st_r.pin_sync;

        if (!pulse_input_enable_in) begin
            st_nxt.gate_cnt = '0;                                              // R18
            st_nxt.edge_cnt = '0;
            st_nxt.hertz    = '0;                                              // R21
            st_nxt.pct      = '0;                                              // R21
            st_nxt.filt_acc = '0;
        end else begin
            if (rise && st_r.edge_cnt < `HZ_MAX) begin
                st_nxt.edge_cnt = st_r.edge_cnt + 16'h1;
            end
            if (st_r.gate_cnt == 25'(GATE_CYCLES - 1)) begin
                st_nxt.gate_cnt = '0;
                st_nxt.edge_cnt = '0;
                st_nxt.hertz    = st_r.edge_cnt;                               // R17
            end else begin
                st_nxt.gate_cnt = st_r.gate_cnt + 25'h1;
            end
            st_nxt.pct = hz_to_pct(st_r.hertz);                                // R16
            // first-order low pass, a step every tick, state in 1/256 of 0.1 %
            if (st_r.tick_cnt == 25'(TICK_CYCLES - 1)) begin
                target = 32'(st_r.pct) <<< 8;
                delta  = (target - st_r.filt_acc)
                         / $signed({21'h0, shared_filter_constant_in} + 32'sd1); // R15
                st_nxt.filt_acc = st_r.filt_acc + delta;                       // R15
            end
        end
        if (st_r.tick_cnt == 25'(TICK_CYCLES - 1)) begin
            st_nxt.tick_cnt = '0;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 25'h1;
        end

        st_nxt.ao1_pct   = ao_ratio(output1_source_select_in, output1_gain_in);
        st_nxt.ao2_pct   = ao_ratio(output2_source_select_in, output2_gain_in);
        st_nxt.ao1_level = level_of(output1_span_select_in, st_r.ao1_pct);
        st_nxt.ao2_level = level_of(output2_span_select_in, st_r.ao2_pct);
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            // synchroniser and edge detector start at the pin's pulled-up idle level
            st_r <= '{pin_meta: 1'b1, pin_sync: 1'b1, pin_prev: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse_input_percent_out      = st_r.pct;
    assign pulse_input_hertz_out        = st_r.hertz;
    assign pulse_input_filtered_out     = st_r.filt_acc[23:8];
    assign digital_input_status_out     = pulse_input_enable_in ? 1'b0 : st_r.pin_sync; // R21
    assign second_input_function_out    = ~pulse_input_enable_in;                       // R21
    assign output1_percent_readback_out = st_r.ao1_pct;
    assign output2_percent_readback_out = st_r.ao2_pct;
    assign first_level_output_out       = st_r.ao1_level;
    assign second_level_output_out      = st_r.ao2_level;

    property p_disabled_zero;
        @(posedge clock_in) disable iff (!rst_n_in)
        !pulse_input_enable_in |=> (pulse_input_hertz_out == '0 && pulse_input_percent_out == '0);
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) // R18
        else $error("frequency readbacks not zero while disabled");

    property p_status_forced;
        @(posedge clock_in) disable iff (!rst_n_in)
        pulse_input_enable_in |-> (!digital_input_status_out && !second_input_function_out);
    endproperty
    a_status_forced: assert property (p_status_forced) // R21
        else $error("pin status not forced while frequency input enabled");

    property p_hertz_limit;
        @(posedge clock_in) disable iff (!rst_n_in)
        pulse_input_hertz_out <= `HZ_MAX;
    endproperty
    a_hertz_limit: assert property (p_hertz_limit) // R17
        else $error("hertz readback above limit");

    property p_hertz_at_gate;
        @(posedge clock_in) disable iff (!rst_n_in)
        (pulse_input_enable_in && $changed(st_r.hertz)) |-> st_r.gate_cnt == '0;
    endproperty
    a_hertz_at_gate: assert property (p_hertz_at_gate) // R17
        else $error("hertz changed away from gate end");

    property p_pct_range;
        @(posedge clock_in) disable iff (!rst_n_in)
        $signed(pulse_input_percent_out) <= 16'sd1000
            && $signed(pulse_input_percent_out) >= -16'sd1000;
    endproperty
    a_pct_range: assert property (p_pct_range) // R16
        else $error("percent readback out of range");

    property p_ao_range;
        @(posedge clock_in) disable iff (!rst_n_in)
        output1_percent_readback_out <= 10'(`PCT_FULL)
            && output2_percent_readback_out <= 10'(`PCT_FULL);
    endproperty
    a_ao_range: assert property (p_ao_range) // R23
        else $error("output percent outside span");

    property p_torque_full;
        @(posedge clock_in) disable iff (!rst_n_in)
        (output1_source_select_in == `FN_TORQUE && motor_torque_in == 16'sd2000
            && output1_gain_in == `UNITY_GAIN) |=> output1_percent_readback_out == 10'd1000;
    endproperty
    a_torque_full: assert property (p_torque_full) // R5
        else $error("torque at full scale not at 100 percent");

    property p_direct_volt;
        @(posedge clock_in) disable iff (!rst_n_in)
        output1_span_select_in == `SPAN_0_10V
            |=> first_level_output_out == 16'($past(output1_percent_readback_out) * 10);
    endproperty
    a_direct_volt: assert property (p_direct_volt) // R10
        else $error("0-10 V level mismatch");

    property p_reverse_volt;
        @(posedge clock_in) disable iff (!rst_n_in)
        output2_span_select_in == `SPAN_10_0V
            |=> second_level_output_out
                == `LVL_10V - 16'($past(output2_percent_readback_out) * 10);
    endproperty
    a_reverse_volt: assert property (p_reverse_volt) // R11
        else $error("10-0 V level mismatch");

    property p_live_zero;
        @(posedge clock_in) disable iff (!rst_n_in)
        output1_span_select_in == `SPAN_4_20MA ##1 output1_span_select_in == `SPAN_4_20MA
            |-> first_level_output_out >= `LVL_4MA && first_level_output_out <= `LVL_20MA;
    endproperty
    a_live_zero: assert property (p_live_zero) // R10
        else $error("4-20 mA level outside span");

    property p_unused_zero;
        @(posedge clock_in) disable iff (!rst_n_in)
        (output2_source_select_in == 8'h01 || output2_source_select_in == 8'h11)
            |=> output2_percent_readback_out == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) // R1
        else $error("unused function code gave a nonzero output");

    property p_reverse_live;
        @(posedge clock_in) disable iff (!rst_n_in)
        output2_span_select_in == `SPAN_20_4MA ##1 output2_span_select_in == `SPAN_20_4MA
            |-> second_level_output_out >= `LVL_4MA && second_level_output_out <= `LVL_20MA;
    endproperty
    a_reverse_live: assert property (p_reverse_live) // R11
        else $error("20-4 mA level outside span");

    property p_filt_range;
        @(posedge clock_in) disable iff (!rst_n_in)
        $signed(pulse_input_filtered_out) <= 16'sd1000
            && $signed(pulse_input_filtered_out) >= -16'sd1000;
    endproperty
    a_filt_range: assert property (p_filt_range) // R15
        else $error("filtered frequency value out of range");

endmodule

// file: pulse_source.sv
`timescale 1ns/1ps
// far-side pulse generator on the second digital input; idles high through the
// sinking pull-up, so rising edges are counted while running, plus one if it stops while low
module pulse_source #(
    parameter int HALF_NS = 500
) (
    input  wire logic run_in,  // emit pulses
    output wire logic pin_out  // pulse line
);
    logic wave = 1'b1;
    // the line returns to its pulled-up idle level as soon as the source stops
    assign pin_out = run_in ? wave : 1'b1;
    initial begin
        #13;
        forever begin
            if (run_in) begin
                wave = ~wave;
                #(HALF_NS);
            end else begin
                wave = 1'b1;
                #50;
            end
        end
    end
endmodule

// file: scaling_cfg.svh
`ifndef SCALING_CFG_SVH
`define SCALING_CFG_SVH

// clock and timing
`define CLK_FREQ_KHZ        20000
`define GATE_TIME_MS        1000
`define FILT_TICK_MS        10

// analog output source function codes
`define FN_SPEED_REF        8'h00
`define FN_ACTUAL_SPEED     8'h02
`define FN_OUT_CURRENT      8'h05
`define FN_ACTIVE_CURRENT   8'h06
`define FN_OUT_POWER        8'h07
`define FN_TORQUE           8'h09
`define FN_LOGIC_VALUE      8'h0a
`define FN_OVERLOAD         8'h0c
`define FN_USER_A           8'h0d
`define FN_USER_B           8'h0e
`define FN_EXT_CONTROLLER   8'h10
`define FN_USER_C           8'h12

// full-scale figures
`define FS_TORQUE_0P1PCT    32'sh0000_07d0
`define FS_RAW_VALUE        32'sh0000_7fff
`define FS_PERCENT_0P1PCT   32'sh0000_03e8
`define POWER_ROOT_X1000    48'sh0000_0000_0a26
`define K_SUPPLY_0          48'sh0000_0000_00f0
`define K_SUPPLY_1          48'sh0000_0000_01e0
`define K_SUPPLY_2          48'sh0000_0000_0258

// span codes and levels (mV or uA)
`define SPAN_0_10V          8'h00
`define SPAN_0_20MA         8'h01
`define SPAN_4_20MA         8'h02
`define SPAN_10_0V          8'h03
`define SPAN_20_0MA         8'h04
`define SPAN_20_4MA         8'h05
`define LVL_10V             16'h2710
`define LVL_20MA            16'h4e20
`define LVL_16MA            16'h3e80
`define LVL_4MA             16'h0fa0

// ratio, percent and frequency limits
`define PCT_FULL            16'h03e8
`define UNITY_GAIN          16'h03e8
`define RATIO_10BIT_MAX     32'sh0000_03ff
`define HZ_MAX              16'h4e20

// reset values of the settings
`define RST_OUT1_SOURCE     8'h10
`define RST_OUT2_SOURCE     8'h05
`define RST_SPAN            8'h00

`endif

// file: scaling_pkg.sv
`include "scaling_cfg.svh"

package scaling_pkg;

    typedef struct packed {
        logic               pin_meta;
        logic               pin_sync;
        logic               pin_prev;
        logic [24:0]        gate_cnt;
        logic [15:0]        edge_cnt;
        logic [15:0]        hertz;
        logic signed [15:0] pct;
        logic [24:0]        tick_cnt;
        logic signed [31:0] filt_acc;
        logic [9:0]         ao1_pct;
        logic [9:0]         ao2_pct;
        logic [15:0]        ao1_level;
        logic [15:0]        ao2_level;
    } scaling_state_t;

endpackage

// file: tb_analog_out_freq_in_scaling.sv
`timescale 1ns/1ps
module tb_analog_out_freq_in_scaling;
    logic        clock_in = 1'b0, rst_n_in = 1'b0, en = 1'b0, run = 1'b0;
    logic [7:0]  src1 = 8'h09, src2 = 8'h09, span1 = 8'h00, span2 = 8'h00;
    logic [15:0] gain1 = 16'h03e8, gain2 = 16'h03e8, ramp = 16'h0384, act = 16'h0384;
    logic [15:0] maxs = 16'h0708, cur = 16'h03e8, actc = 16'h03e8, torq = 16'h03e8;
    logic [15:0] lval = 16'h4000, ovl = 16'h01f4, ua = 16'h4000, ub = 16'h4000;
    logic [15:0] uc = 16'h4000, ext = 16'h01f4, rated = 16'h03e8, pgain = 16'h01f4;
    logic [15:0] bmin = 16'h000a, bmax = 16'h0064, poff = 16'hfed4;
    logic [31:0] pwr = 32'h0000_79c8;
    logic [1:0]  sup = 2'h0;
    logic [10:0] filt = 11'h000;
    logic        pin, dstat, dfunc;
    logic [15:0] ppct, phz, pfilt, lvl1, lvl2;
    logic [9:0]  pct1, pct2;
    int          bad_count = 0, tests_run = 0, cycles = 0;
    always #25 clock_in = ~clock_in;
    pulse_source partner (.run_in(run), .pin_out(pin));
    analog_out_freq_in_scaling #(.GATE_CYCLES(2000), .TICK_CYCLES(50)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in),
        .output1_source_select_in(src1), .output2_source_select_in(src2),
        .output1_gain_in(gain1), .output2_gain_in(gain2),
        .output1_span_select_in(span1), .output2_span_select_in(span2),
        .ramp_input_speed_in(ramp), .actual_output_speed_in(act),
        .maximum_speed_setting_in(maxs), .output_current_in(cur),
        .active_current_in(actc), .output_power_in(pwr), .motor_torque_in(torq),
        .logic_value_in(lval), .motor_overload_level_in(ovl), .user_value_a_in(ua),
        .user_value_b_in(ub), .user_value_c_in(uc), .external_controller_output_in(ext),
        .rated_drive_current_in(rated), .supply_voltage_setting_in(sup),
        .second_digital_input_in(pin), .pulse_input_enable_in(en),
        .pulse_input_gain_in(pgain), .pulse_band_minimum_in(bmin),
        .pulse_band_maximum_in(bmax), .pulse_input_offset_in(poff),
        .shared_filter_constant_in(filt), .pulse_input_percent_out(ppct),
        .pulse_input_hertz_out(phz), .pulse_input_filtered_out(pfilt),
        .digital_input_status_out(dstat), .second_input_function_out(dfunc),
        .output1_percent_readback_out(pct1), .output2_percent_readback_out(pct2),
        .first_level_output_out(lvl1), .second_level_output_out(lvl2));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // expected level in mV or uA for a span code at ratio r in 0.1 %
    function automatic int lvl(input int s, input int r);
        case (s)
            1: return 20000 * r / 1000;
            2: return 16000 * r / 1000 + 4000;
            3: return 10000 - 10000 * r / 1000;
            4: return 20000 - 20000 * r / 1000;
            5: return 20000 - 16000 * r / 1000;
            default: return 10000 * r / 1000;
        endcase
    endfunction
    task automatic t_sources;
        logic [7:0] codes [14] = '{8'h00, 8'h02, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0a,
                                   8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h12, 8'h01, 8'h11};
        for (int i = 0; i < 14; i++) begin
            src1 = codes[i];
            src2 = codes[i];
            step(3);
            check(pct1, (i < 12) ? 500 : 0);
            check(lvl2, (i < 12) ? 5000 : 0);
        end
        src1 = 8'h07;
        for (int k = 1; k < 4; k++) begin
            sup = k[1:0];
            step(3);
            check(pct1, (k == 1) ? 250 : (k == 2) ? 200 : 500);
        end
    endtask
    task automatic t_spans;
        int tq [4] = '{2000, 1000, 6000, -1000};
        int rr [4] = '{1000, 500, 1000, 0};
        src1 = 8'h09;
        src2 = 8'h09;
        for (int j = 0; j < 4; j++) begin
            torq = tq[j][15:0];
            for (int s = 0; s < 6; s++) begin
                span1 = s[7:0];
                span2 = 8'(5 - s);
                step(3);
                check(pct1, rr[j]);
                check(lvl1, lvl(s, rr[j]));
                check(lvl2, lvl(5 - s, rr[j]));
            end
        end
    endtask
    task automatic t_gain;
        torq = 16'h01f4;
        gain1 = 16'h07d0;
        gain2 = 16'h0000;
        step(3);
        check(pct1, 500);
        check(pct2, 0);
    endtask
    task automatic t_freq;
        check(dstat, 1);
        en = 1'b1;
        step(2);
        check(dstat, 0);
        check(dfunc, 0);
        run = 1'b1;
        step(4200);
        check(phz, 100);
        check(ppct, 350);
        check(pfilt, 350);
        en = 1'b0;
        run = 1'b0;
        step(3);
        check(phz, 0);
        check(ppct, 0);
        check(dfunc, 1);
        check(dstat, 1);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        step(8);
        check(pct1, 0);
        check(phz, 0);
        rst_n_in = 1'b1;
        step(2);
        t_sources();
        t_spans();
        t_gain();
        t_freq();
        end_of_test();
    end
endmodule
